// ### src/csd_chip_select_decoder.sv
// Contract
// - Thirteen selects: upper, lower, four mid-range, seven peripheral.
// - Upper, lower, mid decode memory only; peripheral decodes memory or I/O.
// - Upper region ends at top of memory; size sets its start.
// - Lower region starts at zero; size sets its end.
// - Upper and lower block sizes span 1 Kbyte to 256 Kbytes.
// - Mid selects cover one contiguous block, 8 to 512 Kbytes.
// - Each mid select covers its own consecutive quarter of the block.
// - Peripheral block is 896 bytes, one 128-byte slice per select.
// - Peripheral block start lies on any 1 Kbyte boundary.
// - Select needs enable, matching space, address in block, no control-block hit.
// - Read, write, prefetch are memory; I/O read and write are I/O.
// - Interrupt acknowledge and halt cycles never assert a select.
// - After reset only the upper select is configured and active.
// - Select goes active with the address, no extra decode delay.
// - Core, DMA and refresh cycles are all decoded alike.
// - One space choice applies to all seven peripheral selects.
// - Each control holds base address, ready and wait requirements.
// - Alternate control holds mid size, space, pin function, top-three waits.
// - Each select can be disabled so it never asserts.
// - Each select has a wait generator and a ready-ignore option.
// - Ready bit clear waits for ready; set ends on wait count.
// - Two-bit wait field is the least wait states per cycle.
// - Pin function set: top pair are selects; clear: address bits two, one.
`timescale 1ns/1ns
module csd_chip_select_decoder
	import csd_pkg::*;
#(
	parameter int MID_COUNT = CSD_MID_COUNT,
	parameter int PERIPH_COUNT = CSD_PERIPH_COUNT
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [CSD_WORD_W-1:0] ctl_wdata,
	input wire logic write_upper_control,
	input wire logic write_lower_control,
	input wire logic write_mid_control,
	input wire logic write_periph_control,
	input wire logic write_alternate_control,
	input wire logic cycle_start,
	input wire logic cycle_end,
	input wire logic [CSD_ADDR_W-1:0] cycle_addr,
	input wire logic [2:0] cycle_status,
	input wire logic pcb_access,
	input wire logic bus_ready,
	output logic upper_mem_select_n,
	output logic lower_mem_select_n,
	output logic [MID_COUNT-1:0] mid_mem_selects_n,
	output logic [PERIPH_COUNT-1:0] periph_selects_n,
	output logic [1:0] cycle_wait_states,
	output logic cycle_ready_ignore,
	output logic cycle_done,
	output logic cycle_selected,
	output logic [3:0] group_enabled
);
	typedef enum logic {CSD_IDLE, CSD_ACTIVE} csd_state_e;

	csd_state_e state;
	csd_wait_if w ();

	// Upper select control
	logic [CSD_UL_W-1:0] upper_start;
	logic [1:0] upper_ws;
	logic upper_ign;
	logic upper_dis;
	// Lower select control
	logic [CSD_UL_W-1:0] lower_end;
	logic [1:0] lower_ws;
	logic lower_ign;
	logic lower_dis;
	logic lower_written;
	// Mid select control
	logic [CSD_MID_W-1:0] mid_start;
	logic [1:0] mid_ws;
	logic mid_ign;
	logic mid_dis;
	logic mid_written;
	// Peripheral select control
	logic [CSD_PER_W-1:0] periph_start;
	logic [1:0] periph_ws;
	logic periph_ign;
	logic periph_dis;
	logic periph_written;
	// Shared alternate control
	logic [CSD_ALT_SIZE_W-1:0] alt_size;
	logic alt_pin_fn;
	logic alt_mem_space;
	logic [1:0] alt_ws;
	logic alt_ign;
	logic alt_written;

	// Control word field extraction
	wire logic [1:0] wd_ws = ctl_wdata[CSD_WS_LSB +: CSD_WS_W];
	wire logic wd_ign = ctl_wdata[CSD_RDY_IGN_BIT];
	wire logic wd_dis = ctl_wdata[CSD_DISABLE_BIT];
	wire logic [CSD_UL_W-1:0] wd_ul = ctl_wdata[CSD_UL_LSB +: CSD_UL_W];
	wire logic [CSD_MID_W-1:0] wd_mid = ctl_wdata[CSD_MID_LSB +: CSD_MID_W];
	wire logic [CSD_PER_W-1:0] wd_per = ctl_wdata[CSD_PER_LSB +: CSD_PER_W];
	wire logic [CSD_ALT_SIZE_W-1:0] wd_size = ctl_wdata[CSD_ALT_SIZE_LSB +: CSD_ALT_SIZE_W];

	// Upper and lower are separate; mid and peripheral need the alternate too
	wire logic upper_en = !upper_dis;
	wire logic lower_en = lower_written && !lower_dis;
	wire logic mid_en = mid_written && alt_written && !mid_dis;
	wire logic periph_en = periph_written && alt_written && !periph_dis;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			upper_start <= CSD_UPPER_START_RST;
			upper_ws <= CSD_WS_RST;
			upper_ign <= CSD_RDY_IGN_RST;
			upper_dis <= 1'b0;
		end else if (write_upper_control) begin
			upper_start <= wd_ul;
			upper_ws <= wd_ws;
			upper_ign <= wd_ign;
			upper_dis <= wd_dis;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lower_end <= CSD_LOWER_END_RST;
			lower_ws <= CSD_WS_RST;
			lower_ign <= CSD_RDY_IGN_RST;
			lower_dis <= 1'b0;
			lower_written <= 1'b0;
		end else if (write_lower_control) begin
			lower_end <= wd_ul;
			lower_ws <= wd_ws;
			lower_ign <= wd_ign;
			lower_dis <= wd_dis;
			lower_written <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mid_start <= '0;
			mid_ws <= CSD_WS_RST;
			mid_ign <= CSD_RDY_IGN_RST;
			mid_dis <= 1'b0;
			mid_written <= 1'b0;
		end else if (write_mid_control) begin
			mid_start <= wd_mid;
			mid_ws <= wd_ws;
			mid_ign <= wd_ign;
			mid_dis <= wd_dis;
			mid_written <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			periph_start <= '0;
			periph_ws <= CSD_WS_RST;
			periph_ign <= CSD_RDY_IGN_RST;
			periph_dis <= 1'b0;
			periph_written <= 1'b0;
		end else if (write_periph_control) begin
			periph_start <= wd_per;
			periph_ws <= wd_ws;
			periph_ign <= wd_ign;
			periph_dis <= wd_dis;
			periph_written <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alt_size <= CSD_ALT_SIZE_RST;
			alt_pin_fn <= 1'b0;
			alt_mem_space <= 1'b0;
			alt_ws <= CSD_WS_RST;
			alt_ign <= CSD_RDY_IGN_RST;
			alt_written <= 1'b0;
		end else if (write_alternate_control) begin
			alt_size <= wd_size;
			alt_pin_fn <= ctl_wdata[CSD_ALT_PINFN_BIT];
			alt_mem_space <= ctl_wdata[CSD_ALT_MEMSP_BIT];
			alt_ws <= wd_ws;
			alt_ign <= wd_ign;
			alt_written <= 1'b1;
		end
	end

	// Cycle type classification; every bus master presents the same status
	wire logic mem_cycle = (cycle_status == CSD_ST_MEM_RD) ||
		(cycle_status == CSD_ST_MEM_WR) ||
		(cycle_status == CSD_ST_FETCH);
	wire logic io_cycle = (cycle_status == CSD_ST_IO_RD) ||
		(cycle_status == CSD_ST_IO_WR);
	// Acknowledge, halt and passive codes fall in neither class
	wire logic mem_ok = mem_cycle && !pcb_access;
	wire logic io_ok = io_cycle && !pcb_access;

	// Upper and lower blocks, 1 to 256 Kbytes at the ends of memory
	wire logic [1:0] bank = cycle_addr[CSD_ADDR_W-1 -: 2];
	wire logic [CSD_UL_W-1:0] ul_addr = cycle_addr[CSD_UL_ADDR_LSB +: CSD_UL_W];
	wire logic upper_hit = upper_en && mem_ok &&
		(bank == CSD_UPPER_BANK) && (ul_addr >= upper_start);
	wire logic lower_hit = lower_en && mem_ok &&
		(bank == CSD_LOWER_BANK) && (ul_addr <= lower_end);

	// Mid block measured in quarters of the smallest block size
	wire logic [CSD_MID_W-1:0] mid_addr = cycle_addr[CSD_MID_ADDR_LSB +: CSD_MID_W];
	wire logic [CSD_MIDQ_W-1:0] midq_addr = cycle_addr[CSD_MIDQ_ADDR_LSB +: CSD_MIDQ_W];
	// Start is assumed aligned to the size, so the offset never wraps
	wire logic [CSD_MIDQ_W-1:0] mid_off = midq_addr - {mid_start, 2'h0};
	wire logic mid_in = (mid_addr >= mid_start) &&
		(mid_off < {alt_size, 2'h0});
	logic [1:0] mid_quarter;

	// Quarter index sits at the highest size bit position of the offset
	always_comb begin
		mid_quarter = 2'h0;
		for (int i = 0; i < CSD_ALT_SIZE_W; i++) begin
			if (alt_size[i]) begin
				mid_quarter = 2'(mid_off >> i);
			end
		end
	end

	logic [MID_COUNT-1:0] mid_hit;
	always_comb begin
		for (int j = 0; j < MID_COUNT; j++) begin
			mid_hit[j] = mid_en && mem_ok && mid_in &&
				(mid_quarter == 2'(j));
		end
	end

	// Peripheral block: one 1 Kbyte-aligned page, seven 128-byte slots
	wire logic [CSD_PER_W-1:0] per_addr = cycle_addr[CSD_PER_ADDR_LSB +: CSD_PER_W];
	wire logic [CSD_SLOT_W-1:0] slot = cycle_addr[CSD_SLOT_LSB +: CSD_SLOT_W];
	wire logic per_space = alt_mem_space ? mem_ok : io_ok;
	wire logic per_in = (per_addr == periph_start) &&
		(slot < CSD_SLOT_W'(PERIPH_COUNT));
	logic [PERIPH_COUNT-1:0] periph_hit;

	always_comb begin
		for (int k = 0; k < PERIPH_COUNT; k++) begin
			periph_hit[k] = periph_en && per_space && per_in &&
				(slot == CSD_SLOT_W'(k));
		end
		if (!alt_pin_fn) begin
			periph_hit[CSD_PAIR_LOW] = 1'b0;
			periph_hit[CSD_PAIR_HIGH] = 1'b0;
		end
	end

	// Per-group hits and their wait requirements
	logic [CSD_GROUPS-1:0] g_hit;
	logic [1:0] g_ws [CSD_GROUPS];
	logic [CSD_GROUPS-1:0] g_ign;

	assign g_hit[CSD_G_UPPER] = upper_hit;
	assign g_hit[CSD_G_LOWER] = lower_hit;
	assign g_hit[CSD_G_MID] = |mid_hit;
	assign g_hit[CSD_G_PLOW] = |periph_hit[CSD_PHIGH_FIRST-1:0];
	assign g_hit[CSD_G_PHIGH] = |periph_hit[PERIPH_COUNT-1:CSD_PHIGH_FIRST];
	assign g_ws[CSD_G_UPPER] = upper_ws;
	assign g_ws[CSD_G_LOWER] = lower_ws;
	assign g_ws[CSD_G_MID] = mid_ws;
	assign g_ws[CSD_G_PLOW] = periph_ws;
	assign g_ws[CSD_G_PHIGH] = alt_ws;
	assign g_ign[CSD_G_UPPER] = upper_ign;
	assign g_ign[CSD_G_LOWER] = lower_ign;
	assign g_ign[CSD_G_MID] = mid_ign;
	assign g_ign[CSD_G_PLOW] = periph_ign;
	assign g_ign[CSD_G_PHIGH] = alt_ign;

	// Overlaps: longest wait wins, ready ignored only if all agree
	logic [1:0] next_ws;
	logic next_ign;
	always_comb begin
		next_ws = 2'h0;
		next_ign = |g_hit;
		for (int g = 0; g < CSD_GROUPS; g++) begin
			if (g_hit[g]) begin
				if (g_ws[g] > next_ws) begin
					next_ws = g_ws[g];
				end
				next_ign = next_ign && g_ign[g];
			end
		end
	end

	// Pair pins follow latched address bits when not used as selects
	wire logic [1:0] pair_addr = {cycle_addr[CSD_PAIR_A_HIGH], cycle_addr[CSD_PAIR_A_LOW]};
	wire logic [1:0] pair_idle = alt_pin_fn ? 2'h3 :
		{periph_selects_n[CSD_PAIR_HIGH], periph_selects_n[CSD_PAIR_LOW]};
	logic [PERIPH_COUNT-1:0] next_periph_n;
	logic [PERIPH_COUNT-1:0] idle_periph_n;
	always_comb begin
		next_periph_n = ~periph_hit;
		idle_periph_n = '1;
		if (!alt_pin_fn) begin
			next_periph_n[CSD_PAIR_HIGH] = pair_addr[1];
			next_periph_n[CSD_PAIR_LOW] = pair_addr[0];
		end
		idle_periph_n[CSD_PAIR_HIGH] = pair_idle[1];
		idle_periph_n[CSD_PAIR_LOW] = pair_idle[0];
	end

	// Selects are captured on the address state edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= CSD_IDLE;
			upper_mem_select_n <= 1'b1;
			lower_mem_select_n <= 1'b1;
			mid_mem_selects_n <= '1;
			periph_selects_n <= '1;
			cycle_wait_states <= 2'h0;
			cycle_ready_ignore <= 1'b0;
			cycle_selected <= 1'b0;
			w.start <= 1'b0;
		end else begin
			w.start <= cycle_start;
			if (cycle_start) begin
				state <= CSD_ACTIVE;
				upper_mem_select_n <= !upper_hit;
				lower_mem_select_n <= !lower_hit;
				mid_mem_selects_n <= ~mid_hit;
				periph_selects_n <= next_periph_n;
				cycle_wait_states <= next_ws;
				cycle_ready_ignore <= next_ign;
				cycle_selected <= |g_hit;
			end else if (state == CSD_ACTIVE && cycle_end) begin
				state <= CSD_IDLE;
				upper_mem_select_n <= 1'b1;
				lower_mem_select_n <= 1'b1;
				mid_mem_selects_n <= '1;
				periph_selects_n <= idle_periph_n;
				cycle_selected <= 1'b0;
			end else if (state == CSD_IDLE) begin
				periph_selects_n <= idle_periph_n;
			end
		end
	end

	// Group enables reported for software visibility
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			group_enabled <= 4'h0;
		end else begin
			group_enabled <= {periph_en, mid_en, lower_en, upper_en};
		end
	end

	assign w.wait_count = cycle_wait_states;
	assign w.ready_ignore = cycle_ready_ignore;
	assign cycle_done = w.done;

	csd_wait_gen u_wait_gen (
		.sys_clk(sys_clk),
		.reset(reset),
		.bus_ready(bus_ready),
		.w(w)
	);
endmodule

// ### src/csd_pkg.sv
package csd_pkg;
	// Bus address and control word widths
	localparam int CSD_ADDR_W = 20;
	localparam int CSD_WORD_W = 16;
	localparam int CSD_MID_COUNT = 4;
	localparam int CSD_PERIPH_COUNT = 7;

	// Cycle status codes presented with the address
	localparam logic [2:0] CSD_ST_INTA = 3'h0;
	localparam logic [2:0] CSD_ST_IO_RD = 3'h1;
	localparam logic [2:0] CSD_ST_IO_WR = 3'h2;
	localparam logic [2:0] CSD_ST_HALT = 3'h3;
	localparam logic [2:0] CSD_ST_FETCH = 3'h4;
	localparam logic [2:0] CSD_ST_MEM_RD = 3'h5;
	localparam logic [2:0] CSD_ST_MEM_WR = 3'h6;
	localparam logic [2:0] CSD_ST_PASSIVE = 3'h7;

	// Control word fields common to all select controls
	localparam int CSD_WS_LSB = 0;
	localparam int CSD_WS_W = 2;
	localparam int CSD_RDY_IGN_BIT = 2;
	localparam int CSD_DISABLE_BIT = 3;

	// Upper and lower block fields, compared with address bits 17:10
	localparam int CSD_UL_LSB = 6;
	localparam int CSD_UL_W = 8;
	localparam int CSD_UL_ADDR_LSB = 10;
	localparam logic [1:0] CSD_UPPER_BANK = 2'h3;
	localparam logic [1:0] CSD_LOWER_BANK = 2'h0;

	// Mid block start, compared with address bits 19:13
	localparam int CSD_MID_LSB = 9;
	localparam int CSD_MID_W = 7;
	localparam int CSD_MID_ADDR_LSB = 13;
	// Quarter granularity of the smallest mid block, address bits 19:11
	localparam int CSD_MIDQ_ADDR_LSB = 11;
	localparam int CSD_MIDQ_W = 9;

	// Peripheral block start on any 1 Kbyte boundary, address bits 19:10
	localparam int CSD_PER_LSB = 6;
	localparam int CSD_PER_W = 10;
	localparam int CSD_PER_ADDR_LSB = 10;
	localparam int CSD_SLOT_LSB = 7;
	localparam int CSD_SLOT_W = 3;

	// Shared alternate control fields
	localparam int CSD_ALT_SIZE_LSB = 8;
	localparam int CSD_ALT_SIZE_W = 7;
	localparam int CSD_ALT_PINFN_BIT = 7;
	localparam int CSD_ALT_MEMSP_BIT = 6;

	// Reset values
	localparam logic [7:0] CSD_UPPER_START_RST = 8'hFF;
	localparam logic [7:0] CSD_LOWER_END_RST = 8'h00;
	localparam logic [1:0] CSD_WS_RST = 2'h3;
	localparam logic CSD_RDY_IGN_RST = 1'b0;
	localparam logic [6:0] CSD_ALT_SIZE_RST = 7'h01;

	// Index of each select group in the wait-state merge
	localparam int CSD_G_UPPER = 0;
	localparam int CSD_G_LOWER = 1;
	localparam int CSD_G_MID = 2;
	localparam int CSD_G_PLOW = 3;
	localparam int CSD_G_PHIGH = 4;
	localparam int CSD_GROUPS = 5;
	localparam int CSD_PHIGH_FIRST = 4;
	localparam int CSD_PAIR_LOW = 5;
	localparam int CSD_PAIR_HIGH = 6;
	localparam int CSD_PAIR_A_LOW = 1;
	localparam int CSD_PAIR_A_HIGH = 2;
endpackage

// ### src/csd_wait_if.sv
`timescale 1ns/1ns
interface csd_wait_if;
	logic start;
	logic [1:0] wait_count;
	logic ready_ignore;
	logic done;

	modport ctrl (output start, output wait_count, output ready_ignore, input done);
	modport gen (input start, input wait_count, input ready_ignore, output done);
endinterface

// ### src/csd_wait_gen.sv
`timescale 1ns/1ns
module csd_wait_gen
	import csd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic bus_ready,
	csd_wait_if.gen w
);
	typedef enum logic {CSD_W_IDLE, CSD_W_COUNT} csd_wstate_e;

	csd_wstate_e state;
	logic [1:0] count;
	logic [1:0] limit;
	logic ignore;
	wire logic count_met = (count >= limit);
	// Wait count is a floor; ready extends the cycle unless ignored
	wire logic finish = count_met && (ignore || bus_ready);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= CSD_W_IDLE;
			count <= 2'h0;
			limit <= 2'h0;
			ignore <= 1'b0;
			w.done <= 1'b0;
		end else begin
			w.done <= 1'b0;
			unique case (state)
				CSD_W_IDLE: begin
					if (w.start) begin
						count <= 2'h0;
						limit <= w.wait_count;
						ignore <= w.ready_ignore;
						state <= CSD_W_COUNT;
					end
				end
				CSD_W_COUNT: begin
					if (finish) begin
						w.done <= 1'b1;
						state <= CSD_W_IDLE;
					end else if (!count_met) begin
						count <= count + 2'h1;
					end
				end
			endcase
		end
	end
endmodule

// ### tb/csd_bus_target.sv
`timescale 1ns/1ns
module csd_bus_target (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [12:0] sel_n,
	input wire logic [2:0] lag,
	output logic ready
);
	logic [3:0] held;
	logic picked;
	assign picked = !(&sel_n);
	always_ff @(posedge sys_clk) begin
		if (reset || !picked) held <= 4'h0;
		else if (held != 4'hF) held <= held + 4'h1;
	end
	// Ready only while picked and after its own access time; released it drops low
	assign ready = picked && (held >= {1'b0, lag});
endmodule

// ### tb/csd_chip_select_decoder_assertions.sv
`timescale 1ns/1ns
module csd_chip_select_decoder_assertions
	import csd_pkg::*;
#(
	parameter int MID_COUNT = CSD_MID_COUNT,
	parameter int PERIPH_COUNT = CSD_PERIPH_COUNT
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [CSD_WORD_W-1:0] ctl_wdata,
	input wire logic write_upper_control,
	input wire logic write_lower_control,
	input wire logic write_mid_control,
	input wire logic write_periph_control,
	input wire logic write_alternate_control,
	input wire logic cycle_start,
	input wire logic cycle_end,
	input wire logic [CSD_ADDR_W-1:0] cycle_addr,
	input wire logic [2:0] cycle_status,
	input wire logic pcb_access,
	input wire logic bus_ready,
	input wire logic upper_mem_select_n,
	input wire logic lower_mem_select_n,
	input wire logic [MID_COUNT-1:0] mid_mem_selects_n,
	input wire logic [PERIPH_COUNT-1:0] periph_selects_n,
	input wire logic [1:0] cycle_wait_states,
	input wire logic cycle_ready_ignore,
	input wire logic cycle_done,
	input wire logic cycle_selected,
	input wire logic [3:0] group_enabled
);
	logic [3:0] since;
	logic [6+MID_COUNT:0] low_n;
	logic mem_cyc;
	assign low_n = {periph_selects_n[4:0], mid_mem_selects_n, lower_mem_select_n,
		upper_mem_select_n};
	assign mem_cyc = cycle_status inside {CSD_ST_FETCH, CSD_ST_MEM_RD, CSD_ST_MEM_WR};
	// Cycles elapsed since the address state
	always_ff @(posedge sys_clk) begin
		if (reset || cycle_start) since <= 4'h0;
		else if (since != 4'hF) since <= since + 4'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_open;
		cycle_start && !pcb_access;
	endsequence
	sequence s_top_fetch;
		s_open ##0 (mem_cyc && cycle_addr[19:10] == 10'h3FF && group_enabled[0]);
	endsequence
	a_quiet_inta_halt: assert property (cycle_start && (cycle_status == CSD_ST_INTA ||
		cycle_status == CSD_ST_HALT) |=> &low_n && !cycle_selected) else $error("select on inta or halt");
	a_pcb_blocks_all: assert property (cycle_start && pcb_access |=> &low_n && !cycle_selected)
		else $error("select during control block access");
	a_io_mem_only: assert property (cycle_start && !mem_cyc |=> upper_mem_select_n
		&& lower_mem_select_n && &mid_mem_selects_n) else $error("memory select on non-memory cycle");
	a_top_block_hit: assert property (s_top_fetch |=> !upper_mem_select_n)
		else $error("upper select missed top block");
	a_release_at_end: assert property (cycle_end && !cycle_start |=> &low_n && !cycle_selected)
		else $error("select held after cycle end");
	a_hold_between: assert property (!cycle_start && !cycle_end |=> $stable(low_n))
		else $error("select moved without a bus event");
	a_mid_one_quarter: assert property ($onehot0(~mid_mem_selects_n))
		else $error("more than one mid select");
	a_periph_one_slot: assert property ($onehot0(~periph_selects_n[4:0]))
		else $error("more than one peripheral select");
	a_done_no_ready: assert property (cycle_done && cycle_ready_ignore |->
		since == {2'h0, cycle_wait_states} + 4'h2) else $error("wait count end misplaced");
	a_done_on_ready: assert property (cycle_done && !cycle_ready_ignore |-> $past(bus_ready)
		&& since >= {2'h0, cycle_wait_states} + 4'h2) else $error("cycle ended without ready");
	a_done_one_pulse: assert property (cycle_done |=> !cycle_done)
		else $error("done longer than one cycle");
	a_reset_upper_only: assert property ($fell(reset) |-> ##[0:1] group_enabled == 4'h1)
		else $error("reset enable state wrong");
endmodule
bind csd_chip_select_decoder csd_chip_select_decoder_assertions #(.MID_COUNT(MID_COUNT),
	.PERIPH_COUNT(PERIPH_COUNT)) chk_u (.sys_clk(sys_clk), .reset(reset), .ctl_wdata(ctl_wdata),
	.write_upper_control(write_upper_control), .write_lower_control(write_lower_control),
	.write_mid_control(write_mid_control), .write_periph_control(write_periph_control),
	.write_alternate_control(write_alternate_control), .cycle_start(cycle_start),
	.cycle_end(cycle_end), .cycle_addr(cycle_addr), .cycle_status(cycle_status),
	.pcb_access(pcb_access), .bus_ready(bus_ready), .upper_mem_select_n(upper_mem_select_n),
	.lower_mem_select_n(lower_mem_select_n), .mid_mem_selects_n(mid_mem_selects_n),
	.periph_selects_n(periph_selects_n), .cycle_wait_states(cycle_wait_states),
	.cycle_ready_ignore(cycle_ready_ignore), .cycle_done(cycle_done),
	.cycle_selected(cycle_selected), .group_enabled(group_enabled));

// ### tb/chip_select_decoder_tb.sv
`timescale 1ns/1ns
module chip_select_decoder_tb
	import csd_pkg::*;
;
	logic sys_clk, reset, cycle_start, cycle_end, pcb_access, bus_ready, mdl_rdy, tb_rdy, cyc_q;
	logic wu, wl, wm, wp, wa;
	logic [15:0] ctl_wdata;
	logic [19:0] cycle_addr;
	logic [2:0] cycle_status, lag;
	logic upper_n, lower_n, done, selected, ign;
	logic [3:0] mid_n, gen;
	logic [6:0] per_n;
	logic [1:0] ws;
	logic [16:0] exp_q[$];
	int miscompares, n_checks, mid_s, mid_z, per_s;
	logic [7:0] up_s, lo_e;
	logic [4:0] wrote, dis;
	logic [2:0] wc[CSD_GROUPS];
	logic pinfn, memsp;
	csd_chip_select_decoder dut_u (.sys_clk(sys_clk), .reset(reset), .ctl_wdata(ctl_wdata),
		.write_upper_control(wu), .write_lower_control(wl), .write_mid_control(wm),
		.write_periph_control(wp), .write_alternate_control(wa), .cycle_start(cycle_start),
		.cycle_end(cycle_end), .cycle_addr(cycle_addr), .cycle_status(cycle_status),
		.pcb_access(pcb_access), .bus_ready(bus_ready), .upper_mem_select_n(upper_n),
		.lower_mem_select_n(lower_n), .mid_mem_selects_n(mid_n), .periph_selects_n(per_n),
		.cycle_wait_states(ws), .cycle_ready_ignore(ign), .cycle_done(done),
		.cycle_selected(selected), .group_enabled(gen));
	csd_bus_target mdl_u (.sys_clk(sys_clk), .reset(reset), .sel_n({pinfn ? per_n[6:5] : 2'h3,
		per_n[4:0], mid_n, lower_n, upper_n}), .lag(lag), .ready(mdl_rdy));
	assign bus_ready = mdl_rdy | tb_rdy;
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [12:0] got, input logic [12:0] want, input string what);
		n_checks++;
		if (got !== want) begin
			miscompares++;
			$display("Error %0t %s got %h want %h", $time, what, got, want);
		end
	endtask
	task automatic chk_sel(input logic [12:0] want);
		chk({per_n, mid_n, lower_n, upper_n}, want, "selects");
	endtask
	task automatic chk_ws(input logic [3:0] want);
		chk({9'h0, selected, ign, ws}, {9'h0, want}, "cycle info");
	endtask
	task automatic chk_en(input logic [3:0] want);
		chk({9'h0, gen}, {9'h0, want}, "enables");
	endtask
	function automatic logic [16:0] exp_of(input logic [19:0] a, input logic [2:0] st,
		input logic pcb);
		logic mem, io, any, ig;
		logic [12:0] hit, sel_n;
		logic [1:0] w;
		int off, g;
		mem = st inside {CSD_ST_FETCH, CSD_ST_MEM_RD, CSD_ST_MEM_WR};
		io = st inside {CSD_ST_IO_RD, CSD_ST_IO_WR};
		hit = '0;
		hit[0] = !dis[0] && mem && a[19:18] == 2'h3 && a[17:10] >= up_s;
		hit[1] = wrote[1] && !dis[1] && mem && a[19:18] == 2'h0 && a[17:10] <= lo_e;
		off = int'(a) - mid_s * 8192;
		if (wrote[4] && wrote[2] && !dis[2] && mem && off >= 0 && off < mid_z * 8192) begin
			hit[2 + off / (mid_z * 2048)] = 1'b1;
		end
		off = int'(a) - per_s * 1024;
		if (wrote[4] && wrote[3] && !dis[3] && (memsp ? mem : io) && off >= 0 && off < 896) begin
			hit[6 + off / 128] = 1'b1;
		end
		if (pcb) hit = '0;
		if (!pinfn) hit[12:11] = 2'h0;
		any = |hit;
		ig = any;
		w = 2'h0;
		for (int i = 0; i < 13; i++) begin
			g = i < 2 ? i : (i < 6 ? CSD_G_MID : (i < 10 ? CSD_G_PLOW : CSD_G_PHIGH));
			if (hit[i]) begin
				if (wc[g][1:0] > w) w = wc[g][1:0];
				ig = ig & wc[g][2];
			end
		end
		sel_n = ~hit;
		if (!pinfn) sel_n[12:11] = {a[2], a[1]};
		return {any, ig, w, sel_n};
	endfunction
	always @(posedge sys_clk) cyc_q <= cycle_start;
	always @(negedge sys_clk) begin
		if (cyc_q) begin
			if (exp_q.size() == 0) chk(13'h0, 13'h1, "queue");
			else begin
				chk_sel(exp_q[0][12:0]);
				chk_ws(exp_q[0][16:13]);
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic wr(input int r, input logic [15:0] w);
		ctl_wdata <= w;
		{wa, wp, wm, wl, wu} <= 5'(1 << r);
		@(posedge sys_clk);
		{wa, wp, wm, wl, wu} <= 5'h0;
		wrote[r] = 1'b1;
		dis[r] = w[3];
		wc[r] = w[2:0];
		case (r)
			0: up_s = w[13:6];
			1: lo_e = w[13:6];
			2: mid_s = w[15:9];
			3: per_s = w[15:6];
			default: begin
				mid_z = w[14:8];
				pinfn = w[7];
				memsp = w[6];
				dis[4] = 1'b0;
			end
		endcase
		// Let an edge pass so a following write never reassigns the strobes
		@(posedge sys_clk);
	endtask
	task automatic bus_cycle(input logic [19:0] a, input logic [2:0] st, input logic pcb);
		logic [16:0] e;
		int n;
		e = exp_of(a, st, pcb);
		exp_q.push_back(e);
		lag <= 3'($urandom % 7);
		{cycle_addr, cycle_status, pcb_access, cycle_start} <= {a, st, pcb, 1'b1};
		tb_rdy <= !e[16];
		@(posedge sys_clk);
		cycle_start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge sys_clk);
			n++;
		end
		if (done !== 1'b1) begin
			miscompares++;
			$display("Error %0t cycle never completed", $time);
			test_done();
		end
		@(posedge sys_clk);
		{cycle_end, tb_rdy} <= 2'b10;
		@(posedge sys_clk);
		cycle_end <= 1'b0;
		@(posedge sys_clk);
	endtask
	logic [19:0] tbl[20] = '{20'hE0000, 20'hDFFFF, 20'h03FFF, 20'h04000, 20'h08000, 20'h0A000,
		20'h0C000, 20'h0E000, 20'h0FFFF, 20'h10000, 20'h10400, 20'h10480, 20'h10500, 20'h10580,
		20'h10600, 20'h10680, 20'h10700, 20'h1077F, 20'h10780, 20'h103FF};
	logic [19:0] bases[5] = '{20'hDF000, 20'h03000, 20'h07000, 20'h10300, 20'h0F000};
	logic [2:0] sts[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	initial begin
		{reset, cycle_start, cycle_end, pcb_access, tb_rdy, wu, wl, wm, wp, wa} = 10'h200;
		{ctl_wdata, cycle_addr, cycle_status, lag} = '0;
		{miscompares, n_checks, mid_s, per_s, mid_z} = '0;
		{up_s, lo_e, wrote, dis, pinfn, memsp} = {8'hFF, 8'h00, 12'h0};
		for (int i = 0; i < CSD_GROUPS; i++) wc[i] = 3'h3;
		void'($urandom(32'h35D8));
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_en(4'h1);
		for (int s = 0; s < 8; s++) begin
			bus_cycle(20'hFFFF0, 3'(s), 1'b0);
			bus_cycle(20'h00010, 3'(s), 1'b0);
		end
		bus_cycle(20'hFFC00, CSD_ST_MEM_RD, 1'b1);
		bus_cycle(20'hFFBFF, CSD_ST_MEM_RD, 1'b0);
		wr(0, 16'h2005);
		wr(1, 16'h03C2);
		wr(4, 16'h0486);
		wr(2, 16'h0804);
		wr(3, 16'h1043);
		@(posedge sys_clk);
		chk_en(4'hF);
		for (int i = 0; i < 20; i++) begin
			bus_cycle(tbl[i], i < 10 ? CSD_ST_MEM_WR : CSD_ST_IO_RD, 1'b0);
		end
		for (int i = 0; i < 60; i++) begin
			bus_cycle(bases[$urandom % 5] + 20'($urandom % 8192), sts[$urandom % 5], 1'b0);
		end
		wr(1, 16'h3FC2);
		bus_cycle(20'h08000, CSD_ST_FETCH, 1'b0);
		wr(1, 16'h3FCA);
		bus_cycle(20'h00000, CSD_ST_MEM_RD, 1'b0);
		wr(4, 16'h0446);
		@(posedge sys_clk);
		chk_en(4'hD);
		for (int i = 10; i < 20; i++) bus_cycle(tbl[i], CSD_ST_FETCH, 1'b0);
		bus_cycle(20'h10400, CSD_ST_IO_WR, 1'b0);
		// Mid block at zero with one randomly chosen size takes random addresses across its quarters
		wr(2, 16'h0004);
		wr(4, 16'h0046 | 16'(1 << (8 + $urandom % 7)));
		for (int i = 0; i < 20; i++) begin
			bus_cycle(20'($urandom % (mid_z * 8192)), CSD_ST_MEM_RD, 1'b0);
		end
		test_done();
	end
endmodule
